// file: dv/tb_three_wire_adc_serial_port.sv
/*
  bench for both ends of the three-wire converter port joined by one interface.
  assumes default 20-clock sclk half period; the shared wire is resolved here.
*/
`default_nettype none
module tb_three_wire_adc_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, start_read = 0, read_eight = 0, start_write = 0, last_bit = 0;
  logic [7:0] wr_byte = 8'h00, ctrl_byte;
  logic [9:0] result = 10'h000, rd_data;
  logic busy, done, ctrl_valid;
  int err_count = 0, comparisons = 0, pulses = 0;
  twasp_if link ();
  // undriven wire shows the inverse of its last level rather than a stale value
  assign link.sdata = link.dev_sdo_en ? link.dev_sdo : (link.host_sdo_en ? link.host_sdo : ~last_bit);
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (link.dev_sdo_en || link.host_sdo_en) last_bit <= link.sdata;
    if (ctrl_valid === 1'b1) pulses <= pulses + 1;
  end
  twasp_dev twasp_dev_inst (.clock(clock), .rst_n(rst_n), .link(link.dev), .result(result),
    .ctrl_byte(ctrl_byte), .ctrl_valid(ctrl_valid));
  twasp_host twasp_host_inst (.clock(clock), .rst_n(rst_n), .link(link.host), .start_read(start_read),
    .read_eight(read_eight), .start_write(start_write), .wr_byte(wr_byte), .busy(busy),
    .rd_data(rd_data), .done(done));
  twasp_assertions twasp_assertions_inst (.clock(clock), .rst_n(rst_n), .sclk(link.sclk), .rd_wr(link.rd_wr),
    .dev_sdo(link.dev_sdo), .dev_sdo_en(link.dev_sdo_en), .host_sdo_en(link.host_sdo_en));
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one host operation: pulse the start, then wait for done with a bound
  task automatic run_op(input logic rd, input logic eight, input logic [7:0] b);
    int n;
    n = 0;
    while (busy !== 1'b0) @(negedge clock);
    start_read = rd;
    start_write = !rd;
    read_eight = eight;
    wr_byte = b;
    @(negedge clock);
    start_read = 0;
    start_write = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) chk("done", 10'h001, 10'h000);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1;
    result = 10'h2A5;
    run_op(1, 0, 8'h00);
    chk("read full", 10'h2A5, rd_data);
    result = 10'h15A;
    run_op(1, 0, 8'h00);
    chk("read again", 10'h15A, rd_data);
    result = 10'h3C7;
    run_op(1, 1, 8'h00);
    chk("read eight", 10'h0F1, {2'b00, rd_data[7:0]});
    result = 10'h1E3;
    run_op(1, 0, 8'h00);
    chk("read after cut", 10'h1E3, rd_data);
    $display("test reads done");
    run_op(0, 0, 8'hA5);
    chk("ctrl byte", 10'h0A5, {2'b00, ctrl_byte});
    run_op(0, 0, 8'h3C);
    chk("ctrl byte 2", 10'h03C, {2'b00, ctrl_byte});
    chk("ctrl pulses", 10'h002, pulses[9:0]);
    $display("test writes done");
    end_of_test();
  end
  initial begin
    #60000;
    err_count++;
    end_of_test();
  end
endmodule // tb_three_wire_adc_serial_port
`default_nettype wire

// file: dv/twasp_assertions.sv
/*
  link checker for the three-wire converter port, watching the interface wires only.
  assumes one clock domain and the bench's default host timing.
*/
`default_nettype none
module twasp_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic rd_wr,
  input wire logic dev_sdo,
  input wire logic dev_sdo_en,
  input wire logic host_sdo_en
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_rise_drives_line: assert property ($rose(rd_wr) |-> ##[1:4] dev_sdo_en)
    else $error("device not driving after select rise");
  a_fall_releases: assert property ($fell(rd_wr) |-> ##[1:4] !dev_sdo_en)
    else $error("device still driving after select fall");
  a_write_quiet: assert property (!rd_wr [*5] |-> !dev_sdo_en)
    else $error("device drives during write");
  a_no_contention: assert property (!(dev_sdo_en && host_sdo_en))
    else $error("both ends drive the data line");
  a_host_write_only: assert property (host_sdo_en |-> !rd_wr)
    else $error("host drives data while select high");
  // bits may only move while sclk is low, so each is settled at the rising edge
  a_bit_moves_low: assert property ($changed(dev_sdo) && $past(dev_sdo_en) && dev_sdo_en |-> !sclk)
    else $error("read bit changed while sclk high");
  // sclk rests high between bursts, so select may only move while it is parked there
  a_select_sclk_high: assert property ($changed(rd_wr) |-> sclk)
    else $error("select moved while sclk low");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*8])
    else $error("sclk high phase too short");
endmodule // twasp_assertions
`default_nettype wire

// file: rtl/twasp_dev.sv
/*
  converter end of the three-wire serial port: shifts out the 10-bit result, loads the
  8-bit control byte.
  assumes link pins arrive asynchronously and are synchronised here; the host makes sclk.
*/
`default_nettype none
module twasp_dev #(
  parameter int RESULT_BITS = twasp_pkg::RESULT_BITS,
  parameter int CTRL_BITS = twasp_pkg::CTRL_BITS
) (
  input wire logic clock,
  input wire logic rst_n,
  twasp_if.dev link,
  input wire logic [RESULT_BITS-1:0] result,
  output logic [CTRL_BITS-1:0] ctrl_byte,
  output logic ctrl_valid
);
  logic [2:0] sclk_s;
  logic [2:0] sel_s;
  logic [1:0] din_s;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_rise;
  logic sel_fall;
  logic [RESULT_BITS-1:0] shreg;
  logic first_fall;
  logic [CTRL_BITS-1:0] wr_shift;
  logic [3:0] wr_count;
  logic wr_active;

  // two flops before use; the third stage is only for edge finding
  // sclk and select rest high, so reset to that level or release would fake a rise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_s <= 3'h7;
      sel_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], link.sclk};
      sel_s <= {sel_s[1:0], link.rd_wr};
      din_s <= {din_s[0], link.sdata};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign sel_rise = sel_s[1] & ~sel_s[2];
  assign sel_fall = ~sel_s[1] & sel_s[2];

  // read side: result latched fresh on every select rise, so a cut read starts over
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shreg <= '0;
      first_fall <= 1'b0;
      link.dev_sdo_en <= 1'b0;
      link.dev_sdo <= 1'b0;
    end else if (sel_fall) begin
      link.dev_sdo_en <= 1'b0;
      first_fall <= 1'b0;
    end else if (sel_rise) begin
      shreg <= result;
      link.dev_sdo_en <= 1'b1;
      link.dev_sdo <= result[RESULT_BITS-1];
      first_fall <= 1'b1;
    end else if (link.dev_sdo_en && sclk_fall) begin
      first_fall <= 1'b0;
      if (!first_fall) begin
        // zeros shift in; bits past the tenth read low
        shreg <= {shreg[RESULT_BITS-2:0], 1'b0};
        link.dev_sdo <= shreg[RESULT_BITS-2];
      end
    end
  end

  // write side: armed only by a select fall, eight bits then deaf
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_active <= 1'b0;
      wr_count <= 4'h0;
      wr_shift <= '0;
      ctrl_byte <= '0;
      ctrl_valid <= 1'b0;
    end else begin
      ctrl_valid <= 1'b0;
      if (sel_fall) begin
        wr_active <= 1'b1;
        wr_count <= 4'h0;
      end else if (sel_rise) begin
        wr_active <= 1'b0;
      end else if (wr_active && !sel_s[1] && sclk_rise) begin
        wr_shift <= {wr_shift[CTRL_BITS-2:0], din_s[1]};
        if (wr_count == 4'(CTRL_BITS - 1)) begin
          ctrl_byte <= {wr_shift[CTRL_BITS-2:0], din_s[1]};
          ctrl_valid <= 1'b1;
          wr_active <= 1'b0;
        end
        wr_count <= wr_count + 4'h1;
      end
    end
  end
endmodule // twasp_dev
`default_nettype wire

// file: rtl/twasp_host.sv
/*
  host end: makes the serial clock by division, runs one read or one control write per
  start pulse.
  assumes the converter end samples the link with its own clock.
*/
`default_nettype none
module twasp_host #(
  parameter int RESULT_BITS = twasp_pkg::RESULT_BITS,
  parameter int CTRL_BITS = twasp_pkg::CTRL_BITS,
  parameter int HALF = twasp_pkg::SCLK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  twasp_if.host link,
  input wire logic start_read,
  input wire logic read_eight,
  input wire logic start_write,
  input wire logic [CTRL_BITS-1:0] wr_byte,
  output logic busy,
  output logic [RESULT_BITS-1:0] rd_data,
  output logic done
);
  typedef enum logic [3:0] {
    TWH_IDLE = 4'b0001,
    TWH_SETUP = 4'b0010,
    TWH_SHIFT = 4'b0100,
    TWH_END = 4'b1000
  } twh_state_t;
  twh_state_t state;
  logic is_read;
  logic [7:0] div;
  logic [3:0] bits_left;
  logic [CTRL_BITS-1:0] tx;
  logic [1:0] din_s;
  logic tick;
  logic lead;

  assign tick = (div == 8'(HALF - 1));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      din_s <= 2'h0;
    end else begin
      din_s <= {din_s[0], link.sdata};
    end
  end

  // clock divider and transfer sequence; select parks high so every op starts with an edge
  // sclk parks high too: the opening fall is the one the device does not shift on
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= TWH_IDLE;
      div <= 8'h0;
      lead <= 1'b0;
      link.sclk <= 1'b1;
      link.rd_wr <= 1'b1;
      link.host_sdo <= 1'b0;
      link.host_sdo_en <= 1'b0;
      is_read <= 1'b0;
      bits_left <= 4'h0;
      tx <= '0;
      rd_data <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      div <= tick ? 8'h0 : div + 8'h1;
      case (state)
        TWH_IDLE: begin
          if (start_read || start_write) begin
            is_read <= start_read;
            bits_left <= start_read ? (read_eight ? 4'(twasp_pkg::SHORT_READ_BITS) : 4'(RESULT_BITS)) :
              4'(CTRL_BITS);
            tx <= wr_byte;
            link.rd_wr <= 1'b0; // fresh fall first
            busy <= 1'b1;
            div <= 8'h0;
            state <= TWH_SETUP;
          end
        end
        TWH_SETUP: begin
          if (tick) begin
            link.rd_wr <= is_read;
            link.host_sdo_en <= !is_read;
            link.host_sdo <= tx[CTRL_BITS-1];
            lead <= 1'b1;
            state <= TWH_SHIFT;
          end
        end
        TWH_SHIFT: begin
          if (tick) begin
            link.sclk <= !link.sclk;
            if (link.sclk) begin
              // falling edge; the first one carries no new bit
              lead <= 1'b0;
              if (!lead) begin
                tx <= {tx[CTRL_BITS-2:0], 1'b0};
                link.host_sdo <= tx[CTRL_BITS-2];
              end
            end else begin
              // rising edge: sample, and stop after the last bit with sclk left high
              if (is_read) begin
                rd_data <= {rd_data[RESULT_BITS-2:0], din_s[1]};
              end
              bits_left <= bits_left - 4'h1;
              if (bits_left == 4'h1) begin
                state <= TWH_END;
              end
            end
          end
        end
        TWH_END: begin
          if (tick) begin
            link.host_sdo_en <= 1'b0;
            link.rd_wr <= 1'b1; // select only moves outside the clock bursts
            busy <= 1'b0;
            done <= 1'b1;
            state <= TWH_IDLE;
          end
        end
        default: state <= TWH_IDLE;
      endcase
    end
  end
endmodule // twasp_host
`default_nettype wire

// file: rtl/twasp_if.sv
/*
  the three link wires between host and converter port: serial clock, read/write select,
  shared data line as drive/enable pairs.
  assumes the bench resolves the shared data wire from the two enables.
*/
`default_nettype none
interface twasp_if;
  logic sclk;
  logic rd_wr;
  logic host_sdo;
  logic host_sdo_en;
  logic dev_sdo;
  logic dev_sdo_en;
  logic sdata;
  modport dev (input sclk, input rd_wr, input sdata, output dev_sdo, output dev_sdo_en);
  modport host (output sclk, output rd_wr, output host_sdo, output host_sdo_en, input sdata);
endinterface
`default_nettype wire

// file: rtl/twasp_pkg.sv
/*
  shared constants for the three-wire converter serial port: result and control widths,
  link clock divider for the host end.
  assumes both ends run on one 250 MHz system clock.
*/
`default_nettype none
package twasp_pkg;
  localparam int RESULT_BITS = 10;
  localparam int CTRL_BITS = 8;
  localparam int SHORT_READ_BITS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
endpackage
`default_nettype wire
